// ===== hdl/wwdt_top.sv
// windowed watchdog timer with feed check, warning and reset flag
// ------------------------------------------------------------
// What this block does
// [RULE1] no timely reload lets the count run out and forces chip reset; code resets only with reset_en set, else raises FAULT_IRQ
// [RULE2] windowed mode: reload outside min/max span is a fault
// [RULE3] warning interrupt when count falls to programmed warning point
// [RULE4] software may enable; disable only by hardware or watchdog event
// [RULE5] wrong or unfinished feed sequence gives reset or interrupt if enabled
// [RULE6] readable flag records that last reset came from watchdog
// [RULE7] count held in 24-bit timer behind internal prescaler
// [RULE8] time-out 256*4 up to 2^24*4 clocks in steps of 4
// [RULE9] plain variant selects INTERNAL_RC_OSCILLATOR, watchdog oscillator or main clock
// [RULE10] windowed variant selects INTERNAL_RC_OSCILLATOR or watchdog oscillator only
// [RULE11] counter steps once every four watchdog clock cycles
// ------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module wwdt_top #(
    parameter bit WINDOWED_VARIANT = 1'b1
) (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic POR_EVENT,
    input wire logic TICK_IRC,
    input wire logic TICK_WDOSC,
    input wire logic TICK_MAIN,
    input wire wwdt_pkg::wwdt_src_e CLK_SEL,
    input wire wwdt_pkg::wwdt_cfg_s CFG,
    input wire logic CFG_WE,
    input wire logic FEED_WE,
    input wire logic [7:0] FEED_DATA,
    input wire logic FLAG_CLR,
    output wwdt_pkg::wwdt_stat_s STATUS,
    output logic WARN_IRQ,
    output logic FAULT_IRQ,
    output logic CHIP_RESET
);
    import wwdt_pkg::*;

    // time-out below the shortest legal period is raised to it
    function automatic logic [23:0] clamp_timeout(input logic [23:0] t);
        clamp_timeout = (t < TIMEOUT_MIN) ? TIMEOUT_MIN : t;
    endfunction

    logic rst_meta_n;
    logic rst_n;
    always_ff @(posedge CLK_SYS or negedge RST_N) begin
        if (!RST_N) begin
            rst_meta_n <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n <= rst_meta_n;
        end
    end

    // ------------------------------------------------------------
    // clock source and prescaler
    // ------------------------------------------------------------
    wwdt_src_e src;
    logic src_tick;
    logic [1:0] presc;
    logic step;

    // [RULE9] [RULE10] source select
    always_comb begin
        case (src)
            WWDT_SRC_IRC: src_tick = TICK_IRC;
            WWDT_SRC_WDOSC: src_tick = TICK_WDOSC;
            WWDT_SRC_MAIN: src_tick = WINDOWED_VARIANT ? 1'b0 : TICK_MAIN;
            default: src_tick = 1'b0;
        endcase
    end

    logic en;
    wwdt_cfg_s cfg;
    logic [23:0] count;
    logic fault;
    logic expire;

    // [RULE7] [RULE11] divide by four
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            presc <= 2'h0;
        end else if (!en) begin
            presc <= 2'h0;
        end else if (src_tick) begin
            presc <= presc + 2'h1;
        end
    end
    assign step = en && src_tick && (presc == PRESCALE_LAST);

    // ------------------------------------------------------------
    // configuration and enable
    // ------------------------------------------------------------
    logic stop_evt;
    assign stop_evt = expire || fault;

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            src <= WWDT_SRC_IRC;
            cfg <= '{enable: 1'b0, reset_en: 1'b0, windowed: 1'b0,
                     timeout: TIMEOUT_RESET, window: WINDOW_RESET, warn: WARN_RESET};
        end else if (CFG_WE) begin
            // [RULE10] main clock refused in windowed variant
            if (!(WINDOWED_VARIANT && CLK_SEL == WWDT_SRC_MAIN)) begin
                src <= CLK_SEL;
            end
            cfg.reset_en <= CFG.reset_en | cfg.reset_en;
            cfg.windowed <= CFG.windowed & WINDOWED_VARIANT;
            // [RULE8] floor time-out at 256 steps
            cfg.timeout <= clamp_timeout(CFG.timeout);
            cfg.window <= CFG.window;
            cfg.warn <= CFG.warn;
        end
    end

    // [RULE4] enable set-only
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            en <= 1'b0;
        end else if (stop_evt) begin
            en <= 1'b0;
        end else if (CFG_WE && CFG.enable) begin
            en <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // feed sequence
    // ------------------------------------------------------------
    wwdt_feed_e feed_st;
    logic [2:0] feed_wait;
    logic feed_ok;
    logic feed_bad;

    // [RULE5] feed checker
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            feed_st <= WWDT_FEED_IDLE;
            feed_wait <= 3'h0;
        end else begin
            case (feed_st)
                WWDT_FEED_IDLE: begin
                    if (FEED_WE && FEED_DATA == FEED_FIRST) begin
                        feed_st <= WWDT_FEED_HALF;
                        feed_wait <= 3'h0;
                    end
                end
                WWDT_FEED_HALF: begin
                    if (FEED_WE || feed_bad) begin
                        feed_st <= WWDT_FEED_IDLE;
                    end else if (step) begin
                        feed_wait <= feed_wait + 3'h1;
                    end
                end
                default: feed_st <= WWDT_FEED_IDLE;
            endcase
        end
    end

    always_comb begin
        feed_ok = 1'b0;
        feed_bad = 1'b0;
        if (en) begin
            case (feed_st)
                WWDT_FEED_IDLE: feed_bad = FEED_WE && FEED_DATA != FEED_FIRST;
                WWDT_FEED_HALF: begin
                    feed_ok = FEED_WE && FEED_DATA == FEED_SECOND;
                    feed_bad = (FEED_WE && FEED_DATA != FEED_SECOND)
                        || (feed_wait == 3'(FEED_WAIT_TICKS));
                end
                default: feed_bad = 1'b0;
            endcase
        end
    end

    // [RULE2] reload outside window is a fault
    logic early;
    assign early = cfg.windowed && (count > cfg.window);
    assign fault = feed_bad || (feed_ok && early);

    // ------------------------------------------------------------
    // down counter
    // ------------------------------------------------------------
    // [RULE1] expiry at end of count
    assign expire = step && (count == 24'h000000);

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            count <= TIMEOUT_RESET;
        end else if (!en) begin
            // load the new period on the enabling write so a windowed first feed is legal
            count <= CFG_WE ? clamp_timeout(CFG.timeout) : cfg.timeout;
        end else if (feed_ok && !early) begin
            count <= cfg.timeout;
        end else if (step && count != 24'h000000) begin
            // [RULE7] one step per prescaled tick
            count <= count - 24'h000001;
        end
    end

    // ------------------------------------------------------------
    // flags and outputs
    // ------------------------------------------------------------
    logic warn_flag;
    logic timeout_flag;
    logic wdt_rst_flag;
    logic rst_req;

    // [RULE3] warning point
    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            warn_flag <= 1'b0;
        end else if (en && count == {14'h0000, cfg.warn} && cfg.warn != 10'h000) begin
            warn_flag <= 1'b1;
        end else if (FLAG_CLR) begin
            warn_flag <= 1'b0;
        end
    end

    assign rst_req = stop_evt && cfg.reset_en;

    always_ff @(posedge CLK_SYS or negedge rst_n) begin
        if (!rst_n) begin
            timeout_flag <= 1'b0;
            CHIP_RESET <= 1'b0;
            FAULT_IRQ <= 1'b0;
        end else begin
            // [RULE1] [RULE5] reset or interrupt
            CHIP_RESET <= rst_req;
            if (stop_evt && !cfg.reset_en) begin
                FAULT_IRQ <= 1'b1;
            end else if (FLAG_CLR) begin
                FAULT_IRQ <= 1'b0;
            end
            if (stop_evt) begin
                timeout_flag <= 1'b1;
            end else if (FLAG_CLR) begin
                timeout_flag <= 1'b0;
            end
        end
    end

    // [RULE6] survives watchdog reset, cleared by power-on
    always_ff @(posedge CLK_SYS) begin
        if (POR_EVENT) begin
            wdt_rst_flag <= 1'b0;
        end else if (rst_req) begin
            wdt_rst_flag <= 1'b1;
        end else if (FLAG_CLR) begin
            wdt_rst_flag <= 1'b0;
        end
    end

    assign WARN_IRQ = warn_flag;
    assign STATUS = '{timeout_flag: timeout_flag, warn_flag: warn_flag,
                      wdt_reset_flag: wdt_rst_flag, running: en, count: count};
endmodule // wwdt_top
`default_nettype wire

// ===== hdl/wwdt_pkg.sv
// package for the windowed watchdog timer block
package wwdt_pkg;
    // ------------------------------------------------------------
    // sizes and reset values
    // ------------------------------------------------------------
    localparam int unsigned COUNT_W = 24;
    localparam logic [23:0] TIMEOUT_MIN = 24'h0000FF;
    localparam logic [23:0] TIMEOUT_RESET = 24'hFFFFFF;
    localparam logic [23:0] WINDOW_RESET = 24'hFFFFFF;
    localparam logic [9:0] WARN_RESET = 10'h000;
    localparam int unsigned PRESCALE_DIV = 4;
    localparam logic [1:0] PRESCALE_LAST = 2'h3;
    localparam logic [7:0] FEED_FIRST = 8'hAA;
    localparam logic [7:0] FEED_SECOND = 8'h55;
    localparam int unsigned FEED_WAIT_TICKS = 4;

    // ------------------------------------------------------------
    // clock source selection
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        WWDT_SRC_IRC = 2'b00,
        WWDT_SRC_WDOSC = 2'b01,
        WWDT_SRC_MAIN = 2'b10
    } wwdt_src_e;

    typedef enum logic [1:0] {
        WWDT_FEED_IDLE = 2'b00,
        WWDT_FEED_HALF = 2'b01
    } wwdt_feed_e;

    // ------------------------------------------------------------
    // configuration carried as one group
    // ------------------------------------------------------------
    typedef struct packed {
        logic enable;
        logic reset_en;
        logic windowed;
        logic [23:0] timeout;
        logic [23:0] window;
        logic [9:0] warn;
    } wwdt_cfg_s;

    typedef struct packed {
        logic timeout_flag;
        logic warn_flag;
        logic wdt_reset_flag;
        logic running;
        logic [23:0] count;
    } wwdt_stat_s;
endpackage

// ===== tb/wwdt_checker.sv
// assertions on the watchdog block ports
`timescale 1ns/1ps
`default_nettype none
module wwdt_checker (
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic CFG_WE,
    input wire logic FEED_WE,
    input wire logic [7:0] FEED_DATA,
    input wire logic FLAG_CLR,
    input wire wwdt_pkg::wwdt_cfg_s CFG,
    input wire wwdt_pkg::wwdt_stat_s STATUS,
    input wire logic WARN_IRQ,
    input wire logic FAULT_IRQ,
    input wire logic CHIP_RESET
);
    import wwdt_pkg::*;
    default clocking @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    logic [23:0] prev;
    wire logic dec;
    always_ff @(posedge CLK_SYS) prev <= STATUS.count;
    assign dec = STATUS.running && (STATUS.count == prev - 24'h000001);
    a_reset_one_cycle: assert property (CHIP_RESET |=> !CHIP_RESET)
        else $error("chip reset longer than one cycle");
    a_reset_sets_flag: assert property (CHIP_RESET |-> ##[0:1] STATUS.wdt_reset_flag)
        else $error("reset flag not set");
    a_no_sw_disable: assert property ($fell(STATUS.running) |-> ##[0:1] (CHIP_RESET || FAULT_IRQ))
        else $error("watchdog stopped without event");
    a_fault_sticky: assert property (FAULT_IRQ && !FLAG_CLR |=> FAULT_IRQ)
        else $error("fault interrupt dropped");
    a_count_steps_one: assert property ($changed(STATUS.count) && STATUS.running && !FAULT_IRQ
        && $past(STATUS.running) && prev != 24'h0 && !$past(FEED_WE) && !$past(CFG_WE) |-> dec)
        else $error("count moved by other than one");
    a_step_gap_four: assert property (dec |=> !dec [*3])
        else $error("count stepped faster than prescaler");
    a_warn_at_point: assert property (STATUS.running && CFG.warn != 10'h000
        && STATUS.count == {14'h0000, CFG.warn} |-> ##[0:1] WARN_IRQ)
        else $error("warning not raised");
    a_feed_reloads: assert property (FEED_WE && FEED_DATA == FEED_SECOND && $past(FEED_WE)
        && $past(FEED_DATA) == FEED_FIRST && STATUS.running && !CFG.windowed
        |=> STATUS.count == ((CFG.timeout < TIMEOUT_MIN) ? TIMEOUT_MIN : CFG.timeout))
        else $error("feed did not reload count");
    c_chip_reset: cover property (CHIP_RESET);
    c_warning: cover property (WARN_IRQ);
    c_fault: cover property ($rose(FAULT_IRQ));
endmodule // wwdt_checker
bind wwdt_top wwdt_checker u_chk (.CLK_SYS, .RST_N, .CFG_WE, .FEED_WE, .FEED_DATA, .FLAG_CLR,
    .CFG, .STATUS, .WARN_IRQ, .FAULT_IRQ, .CHIP_RESET);
`default_nettype wire

// ===== tb/wwdt_top_test.sv
// self-checking testbench for the watchdog block
`timescale 1ns/1ps
`default_nettype none
module wwdt_top_test;
    import wwdt_pkg::*;
    logic CLK_SYS = 0, RST_N = 0, POR_EVENT = 1, CFG_WE = 0, FEED_WE = 0, FLAG_CLR = 0;
    logic TICK_IRC = 0, TICK_WDOSC = 0, TICK_MAIN = 0, ph = 0;
    logic [2:0] tmask = 3'h0;
    logic [7:0] FEED_DATA = 8'h00;
    wwdt_src_e CLK_SEL = WWDT_SRC_IRC;
    wwdt_cfg_s CFG = '0;
    wwdt_stat_s STATUS;
    logic WARN_IRQ, FAULT_IRQ, CHIP_RESET;
    int n_errors = 0, num_checks = 0;
    wwdt_top DUT (.CLK_SYS, .RST_N, .POR_EVENT, .TICK_IRC, .TICK_WDOSC, .TICK_MAIN, .CLK_SEL,
        .CFG, .CFG_WE, .FEED_WE, .FEED_DATA, .FLAG_CLR, .STATUS, .WARN_IRQ, .FAULT_IRQ,
        .CHIP_RESET);
    initial forever #4 CLK_SYS = ~CLK_SYS;
    // source ticks every other cycle on the selected lines
    always @(negedge CLK_SYS) begin
        ph <= ~ph;
        {TICK_MAIN, TICK_WDOSC, TICK_IRC} <= tmask & {3{ph}};
    end
    task automatic give_verdict;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic do_reset;
        tmask = 3'h0;
        RST_N = 0;
        repeat (8) @(negedge CLK_SYS);
        RST_N = 1;
        repeat (3) @(negedge CLK_SYS);
    endtask
    task automatic cfg_w(input logic en, re, win, input logic [23:0] to, wnd, input logic [9:0] wr);
        CFG = '{en, re, win, to, wnd, wr};
        CFG_WE = 1;
        @(negedge CLK_SYS);
        CFG_WE = 0;
        @(negedge CLK_SYS);
    endtask
    task automatic feed2(input logic [7:0] a, input logic [7:0] b);
        FEED_DATA = a;
        FEED_WE = 1;
        @(negedge CLK_SYS);
        FEED_DATA = b;
        @(negedge CLK_SYS);
        FEED_WE = 0;
        @(negedge CLK_SYS);
    endtask
    // bit 0 fault, 1 warning, 2 chip reset
    task automatic wait_for(input int b, input int n);
        int i;
        logic [2:0] v;
        for (i = 0; i < n; i++) begin
            @(negedge CLK_SYS);
            v = {CHIP_RESET, WARN_IRQ, FAULT_IRQ};
            if (v[b] === 1'b1) break;
        end
        num_checks++;
        if (i == n) begin
            n_errors++;
            $display("[FAIL] wait on event %0d expected 1 seen 0", b);
            give_verdict();
        end
    endtask
    initial begin
        do_reset();
        POR_EVENT = 0;
        chk("count_rst", 24'hFFFFFF, STATUS.count);
        chk("run_rst", 24'h0, STATUS.running);
        cfg_w(1, 0, 0, 24'h000010, 24'hFFFFFF, 10'h000);
        feed2(FEED_FIRST, FEED_SECOND);
        chk("clamp", 24'h0000FF, STATUS.count);
        tmask = 3'h1;
        cfg_w(0, 0, 0, 24'h000010, 24'hFFFFFF, 10'h000);
        chk("no_disable", 24'h1, STATUS.running);
        feed2(FEED_FIRST, 8'h12);
        wait_for(0, 20);
        chk("no_rst_flag", 24'h0, STATUS.wdt_reset_flag);
        do_reset();
        cfg_w(1, 1, 0, 24'h000010, 24'hFFFFFF, 10'h000);
        feed2(FEED_FIRST, FEED_SECOND);
        tmask = 3'h1;
        wait_for(2, 2400);
        @(negedge CLK_SYS);
        chk("rst_flag", 24'h1, STATUS.wdt_reset_flag);
        chk("off", 24'h0, STATUS.running);
        do_reset();
        chk("flag_keep", 24'h1, STATUS.wdt_reset_flag);
        FLAG_CLR = 1;
        @(negedge CLK_SYS);
        FLAG_CLR = 0;
        @(negedge CLK_SYS);
        chk("flag_clr", 24'h0, STATUS.wdt_reset_flag);
        // windowed: warning, then a reload inside the window, then an early one
        cfg_w(1, 0, 1, 24'h0000FF, 24'h000080, 10'h0F0);
        tmask = 3'h1;
        wait_for(1, 400);
        chk("warn_cnt", 24'h0000F0, STATUS.count);
        for (int k = 0; k < 1100 && STATUS.count > 24'h000080; k++) @(negedge CLK_SYS);
        chk("win_reach", 24'h1, STATUS.count <= 24'h000080);
        feed2(FEED_FIRST, FEED_SECOND);
        chk("win_ok", 24'h1, STATUS.count >= 24'h0000FE && !FAULT_IRQ);
        feed2(FEED_FIRST, FEED_SECOND);
        wait_for(0, 20);
        do_reset();
        CLK_SEL = WWDT_SRC_MAIN;
        cfg_w(1, 0, 1, 24'h0000FF, 24'hFFFFFF, 10'h000);
        feed2(FEED_FIRST, FEED_SECOND);
        tmask = 3'h4;
        repeat (40) @(negedge CLK_SYS);
        chk("main_ignored", 24'h0000FF, STATUS.count);
        CLK_SEL = WWDT_SRC_WDOSC;
        cfg_w(1, 0, 1, 24'h0000FF, 24'hFFFFFF, 10'h000);
        tmask = 3'h2;
        repeat (40) @(negedge CLK_SYS);
        chk("wdosc_runs", 24'h1, STATUS.count < 24'h0000FF);
        // first half of a feed left unfinished
        FEED_DATA = FEED_FIRST;
        FEED_WE = 1;
        @(negedge CLK_SYS);
        FEED_WE = 0;
        wait_for(0, 60);
        chk("to_flag", 24'h1, STATUS.timeout_flag);
        give_verdict();
    end
endmodule // wwdt_top_test
`default_nettype wire
